// >>> core/sic_pkg.sv
// constants and carrier types for the serial port and infrared configuration block
package sic_pkg;

  // register port geometry; address bit 8 picks the logical device
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DEV_BIT = 8;
  localparam logic DEV_FIRST = 1'b0;
  localparam logic DEV_SECOND = 1'b1;

  // register indexes inside a logical device
  localparam logic [7:0] OFS_MODE = 8'hf0;
  localparam logic [7:0] OFS_IR_OPT = 8'hf1;
  localparam logic [7:0] OFS_IR_TMO = 8'hf2;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hf8;
  localparam logic [7:0] OFS_IRQ_CLR = 8'hf9;
  localparam logic [7:0] OFS_IRQ_EN = 8'hfa;

  // field positions
  localparam int MIDI_BIT = 0;
  localparam int HS_BIT = 1;
  localparam int SHARE_BIT = 7;
  localparam int RXPOL_BIT = 0;
  localparam int TXPOL_BIT = 1;
  localparam int DUPLEX_BIT = 2;
  localparam int IRMODE_LSB = 3;
  localparam int IRMODE_W = 3;

  // writable bit masks; reserved bits read zero
  localparam logic [7:0] MODE1_MASK = 8'h83;
  localparam logic [7:0] MODE2_MASK = 8'h03;
  localparam logic [7:0] IR_OPT_MASK = 8'h3f;

  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IR_OPT_RST = 8'h02;
  localparam logic [7:0] IR_TMO_RST = 8'h03;

  // infrared mode encodings
  localparam logic [2:0] IR_MODE_COM = 3'h0;
  localparam logic [2:0] IR_MODE_PULSE = 3'h1;
  localparam logic [2:0] IR_MODE_ASK = 3'h2;

  // blanking step time and its cycle count
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_TIME_NS = 100_000;
  localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // interrupt event bits
  localparam int EV_BLANK = 0;
  localparam int EV_PORT1 = 1;
  localparam int EV_PORT2 = 2;
  localparam int EV_N = 3;

  // per port options handed to the serial datapath
  typedef struct packed {
    logic midi;
    logic high_speed;
  } sic_port_cfg_s;

  // last direction that owns the blanking window
  typedef enum logic [1:0] {
    SIC_DIR_NONE,
    SIC_DIR_TX,
    SIC_DIR_RX
  } sic_dir_e;

endpackage

// >>> core/sic_blank_timer.sv
// half duplex blanking timer counted in fixed steps
`timescale 1ns/1ps
module sic_blank_timer
  import sic_pkg::*;
#(
  parameter int STEPS = STEP_CYC,
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [CNT_W-1:0] steps,
  output logic busy,
  output logic done
);

  localparam int PRE_W = $clog2(STEPS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEPS - 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
    logic [PRE_W-1:0] pre;
  } tmr_s;

  tmr_s st;
  tmr_s next_st;

  // step prescaler and step down counter
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (start) begin
      next_st.busy = (steps != '0);
      next_st.done = (steps == '0);
      next_st.cnt = steps;
      next_st.pre = '0;
    end else if (st.busy) begin
      if (st.pre == PRE_LAST) begin
        next_st.pre = '0;
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == CNT_W'(1)) begin
          next_st.busy = 1'b0;
          next_st.done = 1'b1;
        end
      end else begin
        next_st.pre = st.pre + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign done = st.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_zero_no_blank: assert property (ce && start && steps == '0 |=> !busy)
    else $error("zero timeout left blanking active");
  chk_timer_reload: assert property (ce && start && steps != '0 |=>
      busy && st.cnt == $past(steps) && st.pre == '0)
    else $error("timer did not reload on transfer end");
  chk_step_length: assert property (ce && st.busy && !start && st.pre == PRE_LAST |=>
      st.cnt == $past(st.cnt) - 1'b1)
    else $error("step count not decremented at step end");

endmodule

// >>> core/sic_config.sv
// serial port options, interrupt sharing and infrared front end
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module sic_config
  import sic_pkg::*;
#(
  parameter int SEL_W = 4,
  parameter int STEP_CYCLES = STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  input wire logic port1_irq_raw,
  input wire logic port2_irq_raw,
  input wire logic [SEL_W-1:0] port1_irq_sel,
  input wire logic [SEL_W-1:0] port2_irq_sel,
  output logic port1_irq_line,
  output logic port2_irq_line,
  output sic_port_cfg_s first_serial_port_cfg,
  output sic_port_cfg_s second_serial_port_cfg,
  output logic [IRMODE_W-1:0] ir_mode,
  input wire logic uart_tx,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic ir_rx_pin,
  output logic ir_tx_pin,
  output logic uart_rx
);

  typedef struct packed {
    logic [7:0] mode1;
    logic [7:0] mode2;
    logic [7:0] ir_opt;
    logic [7:0] ir_tmo;
    logic [EV_N-1:0] stat;
    logic [EV_N-1:0] en;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic line1;
    logic line2;
    logic raw1_q;
    logic raw2_q;
    logic tx_q;
    logic rx_q;
    sic_dir_e dir;
    logic ir_tx;
    logic uart_rx;
  } cfg_s;

  cfg_s st;
  cfg_s next_st;

  logic dev_second;
  logic [7:0] ofs;
  logic wr_mode1;
  logic wr_mode2;
  logic wr_opt;
  logic wr_tmo;
  logic wr_clr;
  logic wr_en;
  logic share;
  logic half;
  logic [IRMODE_W-1:0] mode_f;
  logic ir_on;
  logic tx_end;
  logic rx_end;
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic blank_rx;
  logic blank_tx;
  logic any_raw;
  logic [EV_N-1:0] ev;

  // address decode
  assign dev_second = addr[DEV_BIT];
  assign ofs = addr[7:0];
  assign wr_mode1 = wr && dev_second == DEV_FIRST && ofs == OFS_MODE;
  assign wr_mode2 = wr && dev_second == DEV_SECOND && ofs == OFS_MODE;
  assign wr_opt = wr && dev_second == DEV_SECOND && ofs == OFS_IR_OPT;
  assign wr_tmo = wr && dev_second == DEV_SECOND && ofs == OFS_IR_TMO;
  assign wr_clr = wr && dev_second == DEV_FIRST && ofs == OFS_IRQ_CLR;
  assign wr_en = wr && dev_second == DEV_FIRST && ofs == OFS_IRQ_EN;

  // option fields
  assign share = st.mode1[SHARE_BIT];
  assign half = st.ir_opt[DUPLEX_BIT];
  assign mode_f = st.ir_opt[IRMODE_LSB +: IRMODE_W];
  // only defined infrared codes enable the front end
  assign ir_on = (mode_f == IR_MODE_PULSE) || (mode_f == IR_MODE_ASK);

  // transfer end detection feeds the blanking timer
  assign tx_end = st.tx_q && !tx_active;
  assign rx_end = st.rx_q && !rx_active;
  assign tmr_start = half && (tx_end || rx_end);

  sic_blank_timer #(
    .STEPS(STEP_CYCLES),
    .CNT_W(8)
  ) u_blank (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(tmr_start),
    .steps(st.ir_tmo),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // timer extends blanking past the transfer
  // registered copy covers the cycle before the timer starts, so no gap opens
  assign blank_rx = half && (tx_active || st.tx_q || (tmr_busy && st.dir == SIC_DIR_TX));
  assign blank_tx = half && (rx_active || st.rx_q || (tmr_busy && st.dir == SIC_DIR_RX));

  assign any_raw = port1_irq_raw || port2_irq_raw;

  // interrupt events: blanking end and rising port interrupts
  always_comb begin
    ev = '0;
    ev[EV_BLANK] = tmr_done;
    ev[EV_PORT1] = port1_irq_raw && !st.raw1_q;
    ev[EV_PORT2] = port2_irq_raw && !st.raw2_q;
  end

  // next state of the whole block
  always_comb begin
    next_st = st;
    next_st.raw1_q = port1_irq_raw;
    next_st.raw2_q = port2_irq_raw;
    next_st.tx_q = tx_active;
    next_st.rx_q = rx_active;
    // high speed bits written per port
    if (wr_mode1) begin
      next_st.mode1 = wdata & MODE1_MASK;
    end
    if (wr_mode2) begin
      next_st.mode2 = wdata & MODE2_MASK;
    end
    // polarity and mode fields held here
    if (wr_opt) begin
      next_st.ir_opt = wdata & IR_OPT_MASK;
    end
    if (wr_tmo) begin
      next_st.ir_tmo = wdata;
    end
    if (wr_en) begin
      next_st.en = wdata[EV_N-1:0];
    end
    // set wins over a clear in the same cycle
    next_st.stat = (st.stat & ~(wr_clr ? wdata[EV_N-1:0] : '0)) | ev;
    next_st.irq = |(next_st.stat & next_st.en);
    // remember which transfer opened the window
    if (tx_end) begin
      next_st.dir = SIC_DIR_TX;
    end else if (rx_end) begin
      next_st.dir = SIC_DIR_RX;
    end
    // shared: every routed line follows either port
    if (share) begin
      next_st.line1 = any_raw && port1_irq_sel != '0;
      next_st.line2 = any_raw && port2_irq_sel != '0;
    end else begin
      next_st.line1 = port1_irq_raw && port1_irq_sel != '0;
      next_st.line2 = port2_irq_raw && port2_irq_sel != '0;
    end
    if (ir_on) begin
      next_st.ir_tx = (uart_tx && !blank_tx) ^ st.ir_opt[TXPOL_BIT];
      next_st.uart_rx = (ir_rx_pin ^ st.ir_opt[RXPOL_BIT]) && !blank_rx;
    end else begin
      next_st.ir_tx = uart_tx;
      next_st.uart_rx = ir_rx_pin;
    end
    // register read, answer in the next cycle
    next_st.rdata = '0;
    if (rd) begin
      case ({dev_second, ofs})
        {DEV_FIRST, OFS_MODE}: next_st.rdata = st.mode1;
        {DEV_FIRST, OFS_IRQ_STAT}: next_st.rdata = DATA_W'(st.stat);
        {DEV_FIRST, OFS_IRQ_EN}: next_st.rdata = DATA_W'(st.en);
        {DEV_SECOND, OFS_MODE}: next_st.rdata = st.mode2;
        {DEV_SECOND, OFS_IR_OPT}: next_st.rdata = st.ir_opt;
        {DEV_SECOND, OFS_IR_TMO}: next_st.rdata = st.ir_tmo;
        default: next_st.rdata = '0;
      endcase
    end
  end

  // state register with reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.mode1 <= MODE_RST;
      st.mode2 <= MODE_RST;
      st.ir_opt <= IR_OPT_RST;
      st.ir_tmo <= IR_TMO_RST;
      st.dir <= SIC_DIR_NONE;
      st.ir_tx <= 1'b0;
      st.uart_rx <= 1'b0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign rdata = st.rdata;
  assign irq = st.irq;
  assign port1_irq_line = st.line1;
  assign port2_irq_line = st.line2;
  assign first_serial_port_cfg.midi = st.mode1[MIDI_BIT];
  assign first_serial_port_cfg.high_speed = st.mode1[HS_BIT];
  assign second_serial_port_cfg.midi = st.mode2[MIDI_BIT];
  assign second_serial_port_cfg.high_speed = st.mode2[HS_BIT];
  assign ir_mode = mode_f;
  assign ir_tx_pin = st.ir_tx;
  assign uart_rx = st.uart_rx;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_mode1_write;
    ce && wr_mode1;
  endsequence

  sequence s_tx_done_half;
    ce && half && ir_on && tx_end && st.ir_tmo != '0;
  endsequence

  chk_midi_write: assert property (s_mode1_write |=>
      first_serial_port_cfg.midi == $past(wdata[MIDI_BIT]))
    else $error("midi bit did not follow write");
  chk_speed_write: assert property (ce && wr_mode2 |=>
      second_serial_port_cfg.high_speed == $past(wdata[HS_BIT]))
    else $error("high speed bit did not follow write");
  chk_separate_lines: assert property (ce && !share && !port1_irq_raw |=>
      !port1_irq_line)
    else $error("separate line asserted without own interrupt");
  chk_shared_lines: assert property (ce && share && port1_irq_raw &&
      port2_irq_sel != '0 |=> port2_irq_line)
    else $error("shared line missed other port interrupt");
  chk_rx_polarity: assert property (ce && ir_on && !half |=>
      uart_rx == $past(ir_rx_pin ^ st.ir_opt[RXPOL_BIT]))
    else $error("receive polarity wrong");
  chk_tx_polarity: assert property (ce && ir_on && !half |=>
      ir_tx_pin == $past(uart_tx ^ st.ir_opt[TXPOL_BIT]))
    else $error("transmit polarity wrong");
  chk_half_blank: assert property (ce && half && ir_on && tx_active |=> !uart_rx)
    else $error("receive not blanked during transmit");
  chk_com_bypass: assert property (ce && mode_f == IR_MODE_COM |=>
      uart_rx == $past(ir_rx_pin) && ir_tx_pin == $past(uart_tx))
    else $error("plain serial mode altered the lines");
  chk_blank_after: assert property (s_tx_done_half ##1 ce && !tx_active && ir_on
      |-> tmr_busy && st.dir == SIC_DIR_TX)
    else $error("blanking window not opened after transmit");
  chk_tmo_reset: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> st.ir_tmo == IR_TMO_RST && st.ir_opt == IR_OPT_RST)
    else $error("infrared registers not at reset value");

endmodule

// >>> test/sic_ir_xcvr.sv
// infrared transceiver model facing the optical pins of the block
`timescale 1ns/1ps
module sic_ir_xcvr (
  input wire logic clk,
  input wire logic light,
  input wire logic rx_low,
  input wire logic ir_tx_pin,
  output logic ir_rx_pin,
  output logic lit
);
  // receiver follows the light, inverted for an active-low part
  assign ir_rx_pin = light ^ rx_low;
  // emitter level as sampled at each rising edge
  always_ff @(posedge clk) begin
    lit <= ir_tx_pin;
  end
endmodule

// >>> test/testbench.sv
// self-checking bench for the serial port and infrared configuration block
`timescale 1ns/1ps
module testbench;
  import sic_pkg::*;
  typedef struct packed {
    logic [8:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } sic_tb_row_s;
  logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, irq, raw1 = 0, raw2 = 0;
  logic [8:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic [3:0] sel1 = 0, sel2 = 0;
  logic line1, line2, uart_tx = 0, tx_act = 0, rx_act = 0;
  logic ir_rx_pin, ir_tx_pin, uart_rx, light = 0, rx_low = 0;
  logic [2:0] ir_mode;
  sic_port_cfg_s cfg1, cfg2;
  int num_errors = 0, n_tests = 0, cyc = 0;
  // register writes, read back with reserved bits dropped
  sic_tb_row_s rows [7] = '{
    '{9'h0f0, 8'hff, 8'h83}, '{9'h1f0, 8'hff, 8'h03}, '{9'h1f1, 8'hff, 8'h3f},
    '{9'h1f2, 8'ha5, 8'ha5}, '{9'h0f1, 8'hff, 8'h00}, '{9'h0fa, 8'h07, 8'h07},
    '{9'h1f0, 8'h01, 8'h01}};

  sic_config #(.STEP_CYCLES(4)) uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .port1_irq_raw(raw1),
    .port2_irq_raw(raw2), .port1_irq_sel(sel1), .port2_irq_sel(sel2),
    .port1_irq_line(line1), .port2_irq_line(line2), .first_serial_port_cfg(cfg1),
    .second_serial_port_cfg(cfg2), .ir_mode(ir_mode), .uart_tx(uart_tx),
    .tx_active(tx_act), .rx_active(rx_act), .ir_rx_pin(ir_rx_pin),
    .ir_tx_pin(ir_tx_pin), .uart_rx(uart_rx));
  sic_ir_xcvr xcvr (.clk(clk), .light(light), .rx_low(rx_low), .ir_tx_pin(ir_tx_pin),
    .ir_rx_pin(ir_rx_pin), .lit());

  // clock of 100 ns period
  always #50 clk = ~clk;

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask

  task rd_chk(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata, e);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task test_done;
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // hang guard, about 140 cycles expected
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    light = 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    chk("cfg1", cfg1, 8'h03);
    chk("cfg2", cfg2, 8'h02);
    chk("ir_mode", ir_mode, 8'h07);
    // reset brings back the defaults
    @(posedge clk);
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    rd_chk(9'h0f0, 8'h00);
    rd_chk(9'h1f0, 8'h00);
    rd_chk(9'h1f1, 8'h02);
    rd_chk(9'h1f2, 8'h03);
    rd_chk(9'h0fa, 8'h00);
    // clock enable low freezes the registers
    ce <= 0;
    wr_reg(9'h1f2, 8'h55);
    ce <= 1;
    rd_chk(9'h1f2, 8'h03);
    // separate lines, sticky status, mask and clear
    @(posedge clk);
    sel1 <= 3;
    raw1 <= 1;
    settle(2);
    chk("line1", line1, 8'h01);
    chk("line2", line2, 8'h00);
    rd_chk(9'h0f8, 8'h02);
    chk("irq masked", irq, 8'h00);
    wr_reg(9'h0fa, 8'h02);
    settle(2);
    chk("irq", irq, 8'h01);
    wr_reg(9'h0f9, 8'h02);
    rd_chk(9'h0f8, 8'h00);
    chk("irq clear", irq, 8'h00);
    raw1 <= 0;
    // sharing set up in host order, then with two routed lines
    wr_reg(9'h0f0, 8'h80);
    raw2 <= 1;
    settle(2);
    chk("shared line1", line1, 8'h01);
    chk("shared line2", line2, 8'h00);
    @(posedge clk);
    sel2 <= 5;
    raw2 <= 0;
    raw1 <= 1;
    settle(2);
    chk("both line2", line2, 8'h01);
    chk("both line1", line1, 8'h01);
    raw1 <= 0;
    // drop port events so only the blanking event remains later
    wr_reg(9'h0f9, 8'h07);
    // infrared mode codes 0 to 3 with the transmit polarity bit set
    uart_tx <= 1;
    for (int m = 0; m < 4; m++) begin
      wr_reg(9'h1f1, {2'b00, m[2:0], 3'b010});
      settle(2);
      chk("ir_tx", ir_tx_pin, (m == 1 || m == 2) ? 8'h00 : 8'h01);
      chk("uart_rx", uart_rx, 8'h01);
    end
    // active-low receiver
    wr_reg(9'h1f1, 8'h0b);
    rx_low <= 1;
    settle(2);
    chk("rx low", uart_rx, 8'h01);
    // full duplex: no blanking while sending
    wr_reg(9'h1f1, 8'h0a);
    rx_low <= 0;
    tx_act <= 1;
    settle(3);
    chk("full dup", uart_rx, 8'h01);
    // half duplex, two steps of blanking after send ends
    wr_reg(9'h1f2, 8'h02);
    wr_reg(9'h1f1, 8'h0e);
    settle(3);
    chk("blank tx", uart_rx, 8'h00);
    tx_act <= 0;
    settle(4);
    chk("blank hold", uart_rx, 8'h00);
    settle(12);
    chk("blank end", uart_rx, 8'h01);
    rd_chk(9'h0f8, 8'h01);
    // zero timeout blanks only during transfer
    wr_reg(9'h1f2, 8'h00);
    tx_act <= 1;
    settle(3);
    tx_act <= 0;
    settle(4);
    chk("zero tmo", uart_rx, 8'h01);
    // receive in progress blanks the emitter to its idle level
    rx_act <= 1;
    settle(3);
    chk("tx blank", ir_tx_pin, 8'h01);
    rx_act <= 0;
    test_done();
  end
endmodule
